// ### rtl/dam_top.sv
// Dual analog monitor output: AHB-Lite registers, signal selection,
// scaling and two converter channels.
// Assumes monitored quantities are synchronous to hclk and signed.
`timescale 1ns/10ps
module dam_top
    import dam_pkg::*;
#(
    parameter int SIG_W = 24                         // Width of monitored inputs
)
(
    input  wire logic                    hclk,            // 20 MHz clock
    input  wire logic                    hresetn,         // Async reset, low
    input  wire logic                    hsel,            // Slave select
    input  wire logic [31:0]             haddr,           // Byte address
    input  wire logic [1:0]              htrans,          // Transfer type
    input  wire logic                    hwrite,          // Write when high
    input  wire logic [2:0]              hsize,           // Transfer size
    input  wire logic [31:0]             hwdata,          // Write data
    input  wire logic                    hready,          // Bus ready in
    output logic [31:0]                  hrdata,          // Read data
    output logic                         hreadyout,       // Slave ready
    output logic                         hresp,           // Always OKAY
    input  wire logic signed [SIG_W-1:0] motor_speed,     // mm/s
    input  wire logic signed [SIG_W-1:0] speed_ref,       // mm/s
    input  wire logic signed [SIG_W-1:0] force_ref,       // 0.1 % rated
    input  wire logic signed [SIG_W-1:0] pos_error,       // Reference units
    input  wire logic signed [SIG_W-1:0] amp_error,       // Encoder pulses
    input  wire logic signed [SIG_W-1:0] pos_ref_speed,   // mm/s
    input  wire logic signed [SIG_W-1:0] speed_ff,        // mm/s
    input  wire logic signed [SIG_W-1:0] force_ff,        // 0.1 % rated
    input  wire logic                    pos_ctrl_active, // Position control
    input  wire logic                    pos_complete,    // Positioning done
    input  wire logic                    ref_complete,    // Reference issued
    input  wire logic                    second_gain,     // 2nd gain in use
    output logic signed [15:0]           monitor_one_code, // Channel one code
    output logic signed [15:0]           monitor_two_code  // Channel two code
);

    ////////////////////////////////////////////////////////////////////
    // Registers and bus state

    logic [15:0]        sel1_r;
    logic [15:0]        sel2_r;
    logic signed [15:0] off1_r;
    logic signed [15:0] off2_r;
    logic signed [15:0] mag1_r;
    logic signed [15:0] mag2_r;
    logic               wr_pend_r;
    logic [7:0]         wr_addr_r;
    logic signed [31:0] sig1_r;
    logic signed [31:0] sig2_r;
    logic               clip1;
    logic               clip2;
    logic               addr_phase;
    logic               in_range;
    logic [31:0]        rd_nxt;
    logic signed [15:0] wr_clamped;

    ////////////////////////////////////////////////////////////////////
    // Functions

    // Scale a raw quantity by a Q-format gain into converter codes
    function automatic logic signed [31:0] dam_scale(
        input logic signed [SIG_W-1:0] raw,
        input logic signed [31:0]      gain
    );
        logic signed [63:0] prod;
        prod = (64'(raw) * 64'(gain)) >>> DAM_GAIN_SHIFT;
        return prod[31:0];
    endfunction

    // Pick and scale the quantity named by one selection code
    function automatic logic signed [31:0] dam_select(
        input logic [7:0] code
    );
        logic signed [31:0] val;
        val = '0;
        case (code)
            DAM_SEL_SPEED:    val = dam_scale(motor_speed, DAM_GAIN_PER_K);
            DAM_SEL_SPD_REF:  val = dam_scale(speed_ref, DAM_GAIN_PER_K);
            DAM_SEL_REF_SPD:  val = dam_scale(pos_ref_speed, DAM_GAIN_PER_K);
            DAM_SEL_SPD_FF:   val = dam_scale(speed_ff, DAM_GAIN_PER_K);
            DAM_SEL_FORCE:    val = dam_scale(force_ref, DAM_GAIN_PER_K);
            DAM_SEL_FRC_FF:   val = dam_scale(force_ff, DAM_GAIN_PER_K);
            DAM_SEL_POS_ERR: begin
                // Zero while the drive runs speed or force control
                val = pos_ctrl_active ? dam_scale(pos_error, DAM_GAIN_POS)
                                      : '0;
            end
            DAM_SEL_AMP_ERR:  val = dam_scale(amp_error, DAM_GAIN_POS);
            DAM_SEL_POS_DONE: val = pos_complete ? DAM_CODE_5V : '0;
            DAM_SEL_REF_DONE: val = ref_complete ? DAM_CODE_5V : '0;
            DAM_SEL_GAIN:     val = second_gain ? DAM_CODE_2V : DAM_CODE_1V;
            // Reserved codes show zero signal; only the offset remains
            default:          val = '0;
        endcase
        return val;
    endfunction

    // Clip a written setting into its legal range
    function automatic logic signed [15:0] dam_clamp(
        input logic signed [15:0] v
    );
        logic signed [15:0] r;
        r = v;
        if (v > DAM_SET_MAX) begin
            r = DAM_SET_MAX;
        end else if (v < DAM_SET_MIN) begin
            r = DAM_SET_MIN;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // AHB-Lite address phase capture

    assign addr_phase = hsel & hready & htrans[1];
    assign in_range   = (haddr[31:8] == 24'h000000);
    assign wr_clamped = dam_clamp(hwdata[15:0]);

    // Write address held for the data phase; non-word sizes still land
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
        end else if (hready) begin
            wr_pend_r <= addr_phase & hwrite & in_range;
            wr_addr_r <= haddr[7:0];
        end
    end

    // Zero wait states, every response OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Setting registers, written in the data phase, effective at once

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel1_r <= DAM_RST_SEL1;
            sel2_r <= DAM_RST_SEL2;
        end else if (wr_pend_r) begin
            if (wr_addr_r == DAM_OFS_SEL1) begin
                sel1_r <= hwdata[15:0];
            end
            if (wr_addr_r == DAM_OFS_SEL2) begin
                sel2_r <= hwdata[15:0];
            end
        end
    end

    // Offsets clipped on write so readback shows the value in use
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            off1_r <= DAM_RST_OFF;
            off2_r <= DAM_RST_OFF;
        end else if (wr_pend_r) begin
            if (wr_addr_r == DAM_OFS_OFF1) begin
                off1_r <= wr_clamped;
            end
            if (wr_addr_r == DAM_OFS_OFF2) begin
                off2_r <= wr_clamped;
            end
        end
    end

    // Multipliers, one per channel, unity after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mag1_r <= DAM_RST_MAG;
            mag2_r <= DAM_RST_MAG;
        end else if (wr_pend_r) begin
            if (wr_addr_r == DAM_OFS_MAG1) begin
                mag1_r <= wr_clamped;
            end
            if (wr_addr_r == DAM_OFS_MAG2) begin
                mag2_r <= wr_clamped;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data, prepared in the address phase

    // Mux of register contents; unmapped offsets read zero
    always_comb begin
        rd_nxt = '0;
        case (haddr[7:0])
            DAM_OFS_SEL1:  rd_nxt = {16'h0000, sel1_r};
            DAM_OFS_SEL2:  rd_nxt = {16'h0000, sel2_r};
            DAM_OFS_OFF1:  rd_nxt = {16'h0000, off1_r};
            DAM_OFS_OFF2:  rd_nxt = {16'h0000, off2_r};
            DAM_OFS_MAG1:  rd_nxt = {16'h0000, mag1_r};
            DAM_OFS_MAG2:  rd_nxt = {16'h0000, mag2_r};
            DAM_OFS_CODE1: rd_nxt = {16'h0000, monitor_one_code};
            DAM_OFS_CODE2: rd_nxt = {16'h0000, monitor_two_code};
            DAM_OFS_STAT:  rd_nxt = {30'h00000000, clip2, clip1};
            default:       rd_nxt = '0;
        endcase
        if (!in_range) begin
            rd_nxt = '0;
        end
    end

    // Register the answer; a read right behind a write to the same
    // setting would otherwise see the stale value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (addr_phase & ~hwrite) begin
            if (wr_pend_r && (wr_addr_r == haddr[7:0]) && in_range) begin
                case (haddr[7:0])
                    DAM_OFS_SEL1, DAM_OFS_SEL2: hrdata <= {16'h0000, hwdata[15:0]};
                    DAM_OFS_OFF1, DAM_OFS_OFF2,
                    DAM_OFS_MAG1, DAM_OFS_MAG2: hrdata <= {16'h0000, wr_clamped};
                    default:                    hrdata <= rd_nxt;
                endcase
            end else begin
                hrdata <= rd_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Signal selection per channel, registered to break the long path

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sig1_r <= '0;
            sig2_r <= '0;
        end else begin
            sig1_r <= dam_select(sel1_r[7:0]);
            sig2_r <= dam_select(sel2_r[7:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Converter channels; each has its own multiplier and offset

    dam_channel u_chan_one (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .sig_code (sig1_r),
        .mag      (mag1_r),
        .offset   (off1_r),
        .dac_code (monitor_one_code),
        .clipped  (clip1)
    );

    dam_channel u_chan_two (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .sig_code (sig2_r),
        .mag      (mag2_r),
        .offset   (off2_r),
        .dac_code (monitor_two_code),
        .clipped  (clip2)
    );

endmodule

// ### rtl/dam_pkg.sv
// Shared constants of the dual analog monitor output block.
// Assumes a 16-bit converter with 4096 codes per volt, two's complement.
package dam_pkg;

    // Register byte offsets on the AHB-Lite slave
    localparam logic [7:0] DAM_OFS_SEL1  = 8'h00;
    localparam logic [7:0] DAM_OFS_SEL2  = 8'h04;
    localparam logic [7:0] DAM_OFS_OFF1  = 8'h08;
    localparam logic [7:0] DAM_OFS_OFF2  = 8'h0c;
    localparam logic [7:0] DAM_OFS_MAG1  = 8'h10;
    localparam logic [7:0] DAM_OFS_MAG2  = 8'h14;
    localparam logic [7:0] DAM_OFS_CODE1 = 8'h18;
    localparam logic [7:0] DAM_OFS_CODE2 = 8'h1c;
    localparam logic [7:0] DAM_OFS_STAT  = 8'h20;

    // Values after reset (factory setting)
    localparam logic [15:0] DAM_RST_SEL1 = 16'h0002;
    localparam logic [15:0] DAM_RST_SEL2 = 16'h0000;
    localparam logic [15:0] DAM_RST_OFF  = 16'h0000;
    localparam logic [15:0] DAM_RST_MAG  = 16'h0064;

    // Legal range of offset and multiplier settings
    localparam logic signed [15:0] DAM_SET_MAX = 16'sh2710;
    localparam logic signed [15:0] DAM_SET_MIN = -16'sh2710;

    // Selection codes, low byte of the select registers
    localparam logic [7:0] DAM_SEL_SPEED    = 8'h00;
    localparam logic [7:0] DAM_SEL_SPD_REF  = 8'h01;
    localparam logic [7:0] DAM_SEL_FORCE    = 8'h02;
    localparam logic [7:0] DAM_SEL_POS_ERR  = 8'h03;
    localparam logic [7:0] DAM_SEL_AMP_ERR  = 8'h04;
    localparam logic [7:0] DAM_SEL_REF_SPD  = 8'h05;
    localparam logic [7:0] DAM_SEL_POS_DONE = 8'h08;
    localparam logic [7:0] DAM_SEL_SPD_FF   = 8'h09;
    localparam logic [7:0] DAM_SEL_FRC_FF   = 8'h0a;
    localparam logic [7:0] DAM_SEL_GAIN     = 8'h0b;
    localparam logic [7:0] DAM_SEL_REF_DONE = 8'h0c;

    // Converter codes: 1 V is 4096 codes, linear over +/-8 V
    localparam logic signed [31:0] DAM_CODE_1V = 32'sh0000_1000;
    localparam logic signed [31:0] DAM_CODE_2V = 32'sh0000_2000;
    localparam logic signed [31:0] DAM_CODE_5V = 32'sh0000_5000;
    localparam logic signed [15:0] DAM_CODE_MAX = 16'sh7fff;
    localparam logic signed [15:0] DAM_CODE_MIN = -16'sh8000;

    // Fixed gains in Q10: 1 V per 1000 units, 0.05 V per unit
    localparam int DAM_GAIN_SHIFT = 10;
    localparam logic signed [31:0] DAM_GAIN_PER_K = 32'sh0000_1062;
    localparam logic signed [31:0] DAM_GAIN_POS   = 32'sh0003_3333;
    // Multiplier 0.01x per step in Q20, offset 0.1 V per step in Q10
    localparam int DAM_MAG_SHIFT = 20;
    localparam logic signed [31:0] DAM_MAG_STEP = 32'sh0000_28f6;
    localparam int DAM_OFF_SHIFT = 10;
    localparam logic signed [31:0] DAM_OFF_STEP = 32'sh0006_6666;

endpackage

// ### rtl/dam_channel.sv
// One monitor channel: multiplier, offset, negation and clipping.
// Assumes the scaled signal arrives in converter codes, one per cycle.
`timescale 1ns/10ps
module dam_channel
    import dam_pkg::*;
(
    input  wire logic               hclk,      // System clock
    input  wire logic               hresetn,   // Async reset, active low
    input  wire logic signed [31:0] sig_code,  // Selected signal in codes
    input  wire logic signed [15:0] mag,       // Multiplier, 0.01x steps
    input  wire logic signed [15:0] offset,    // Offset, 0.1 V steps
    output logic signed [15:0]      dac_code,  // Converter code
    output logic                    clipped    // Result was saturated
);

    logic signed [63:0] prod_r;
    logic signed [63:0] ofs_r;
    logic signed [63:0] prod_full;
    logic signed [63:0] sum_full;

    ////////////////////////////////////////////////////////////////////
    // Stage one: signal times multiplier, offset in codes
    assign prod_full = 64'(sig_code) * 64'(mag) * 64'(DAM_MAG_STEP);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prod_r <= '0;
            ofs_r  <= '0;
        end else begin
            prod_r <= prod_full >>> DAM_MAG_SHIFT;
            ofs_r  <= (64'(offset) * 64'(DAM_OFF_STEP)) >>> DAM_OFF_SHIFT;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Stage two: negate the whole sum, then clip to the code range
    assign sum_full = -(prod_r + ofs_r);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dac_code <= '0;
            clipped  <= 1'b0;
        end else if (sum_full > 64'(DAM_CODE_MAX)) begin
            dac_code <= DAM_CODE_MAX;
            clipped  <= 1'b1;
        end else if (sum_full < 64'(DAM_CODE_MIN)) begin
            dac_code <= DAM_CODE_MIN;
            clipped  <= 1'b1;
        end else begin
            dac_code <= sum_full[15:0];
            clipped  <= 1'b0;
        end
    end

endmodule

// ### tb/dam_recorder.sv
// Measuring instrument model: captures both monitor codes each edge.
// Assumes 16-bit two's complement codes from the monitor block.
`timescale 1ns/10ps
module dam_recorder
(
    input  wire logic               hclk,    // Sample clock
    input  wire logic               hresetn, // Reset, active low
    input  wire logic signed [15:0] ch_one,  // Monitor one
    input  wire logic signed [15:0] ch_two,  // Monitor two
    output logic signed [15:0]      rec_one, // Captured monitor one
    output logic signed [15:0]      rec_two  // Captured monitor two
);
    // Full 16-bit capture, no coarser grid of its own
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rec_one <= 16'sh0000;
            rec_two <= 16'sh0000;
        end else begin
            rec_one <= ch_one;
            rec_two <= ch_two;
        end
    end
endmodule

// ### tb/dam_top_asserts.sv
// Checker of the monitor block at its top ports.
// Assumes one slave, hready tied to hreadyout.
`timescale 1ns/10ps
module dam_top_asserts
    import dam_pkg::*;
#(
    parameter int SIG_W = 24 // Monitored width
)
(
    input wire logic                    hclk,            // Clock
    input wire logic                    hresetn,         // Reset, low
    input wire logic                    hsel,            // Select
    input wire logic [31:0]             haddr,           // Address
    input wire logic [1:0]              htrans,          // Transfer type
    input wire logic                    hwrite,          // Write
    input wire logic [31:0]             hwdata,          // Write data
    input wire logic                    hready,          // Ready in
    input wire logic [31:0]             hrdata,          // Read data
    input wire logic                    hreadyout,       // Ready out
    input wire logic                    hresp,           // Response
    input wire logic signed [SIG_W-1:0] motor_speed,     // Speed
    input wire logic signed [SIG_W-1:0] speed_ref,       // Speed ref
    input wire logic signed [SIG_W-1:0] force_ref,       // Force ref
    input wire logic signed [SIG_W-1:0] pos_error,       // Pos error
    input wire logic signed [SIG_W-1:0] amp_error,       // Amp error
    input wire logic signed [SIG_W-1:0] pos_ref_speed,   // Ref speed
    input wire logic signed [SIG_W-1:0] speed_ff,        // Speed ff
    input wire logic signed [SIG_W-1:0] force_ff,        // Force ff
    input wire logic                    pos_ctrl_active, // Pos control
    input wire logic                    pos_complete,    // Pos done
    input wire logic                    ref_complete,    // Ref done
    input wire logic                    second_gain,     // Gain two
    input wire logic signed [15:0]      monitor_one_code, // Code one
    input wire logic signed [15:0]      monitor_two_code  // Code two
);
    logic                  tk;      // Transfer taken
    logic                  wr_q;    // Write data phase
    logic [7:0]            wa_q;    // Its offset
    logic [7:0]            sel1_q;  // Shadow select one
    logic                  off_z;   // Offset one is zero
    logic                  mag_u;   // Multiplier one is unity
    logic [8*SIG_W+3:0]    mon_in;  // All monitored inputs
    assign tk = hsel && hready && htrans[1] && (haddr[31:8] == 24'h0);
    assign mon_in = {motor_speed, speed_ref, force_ref, pos_error, amp_error,
                     pos_ref_speed, speed_ff, force_ff, pos_ctrl_active,
                     pos_complete, ref_complete, second_gain};
    // Data phase tracking, so shadows update when the block does
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            wa_q <= 8'h00;
        end else begin
            wr_q <= tk && hwrite;
            wa_q <= haddr[7:0];
        end
    end
    // Shadows of channel one settings; raw value is enough for these tests
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel1_q <= DAM_RST_SEL1[7:0];
            off_z  <= 1'b1;
            mag_u  <= 1'b1;
        end else if (wr_q) begin
            if (wa_q == DAM_OFS_SEL1) sel1_q <= hwdata[7:0];
            if (wa_q == DAM_OFS_OFF1) off_z <= (hwdata[15:0] == 16'h0000);
            if (wa_q == DAM_OFS_MAG1) mag_u <= (hwdata[15:0] == DAM_RST_MAG);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Four edges with no write and steady inputs
    sequence quiet;
        (hresetn && $past(hresetn) && !(tk && hwrite) && !wr_q && $stable(mon_in)) [*4];
    endsequence
    sequence done_hi;
        quiet ##0 (off_z && mag_u && ((sel1_q == DAM_SEL_POS_DONE && pos_complete) ||
                                      (sel1_q == DAM_SEL_REF_DONE && ref_complete)));
    endsequence
    sequence done_lo;
        quiet ##0 (off_z && mag_u && ((sel1_q == DAM_SEL_POS_DONE && !pos_complete) ||
                                      (sel1_q == DAM_SEL_REF_DONE && !ref_complete)));
    endsequence
    hresp_okay_a: assert property (hresp == 1'b0)
        else $error("hresp not OKAY");
    ready_high_a: assert property ($past(hresetn) |-> hreadyout)
        else $error("hreadyout low after reset");
    offset_range_a: assert property (
        tk && !hwrite && (haddr[7:0] == DAM_OFS_OFF1 || haddr[7:0] == DAM_OFS_OFF2)
        |=> hrdata[31:16] == 16'h0000 && $signed(hrdata[15:0]) >= DAM_SET_MIN &&
            $signed(hrdata[15:0]) <= DAM_SET_MAX)
        else $error("offset readback out of range");
    ch1_settle_a: assert property (quiet |=> $stable(monitor_one_code))
        else $error("channel one moved with steady inputs");
    ch2_settle_a: assert property (quiet |=> $stable(monitor_two_code))
        else $error("channel two moved with steady inputs");
    flag_high_a: assert property (done_hi |=> monitor_one_code == -16'sh5000)
        else $error("completion flag not at five volts");
    flag_low_a: assert property (done_lo |=> monitor_one_code == 16'sh0000)
        else $error("completion flag not at zero");
    pos_err_zero_a: assert property (
        quiet ##0 (off_z && mag_u && sel1_q == DAM_SEL_POS_ERR && !pos_ctrl_active)
        |=> monitor_one_code == 16'sh0000)
        else $error("position error not zero outside position control");
endmodule
bind dam_top dam_top_asserts #(.SIG_W(SIG_W)) u_chk (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .motor_speed,
    .speed_ref, .force_ref, .pos_error, .amp_error, .pos_ref_speed, .speed_ff,
    .force_ff, .pos_ctrl_active, .pos_complete, .ref_complete, .second_gain,
    .monitor_one_code, .monitor_two_code);

// ### tb/dam_top_tb.sv
// Testbench of the monitor block: register access and channel outputs.
// Assumes the recorder model samples both codes each edge.
`timescale 1ns/10ps
module dam_top_tb
    import dam_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic signed [23:0] motor_speed, speed_ref, force_ref, pos_error;
    logic signed [23:0] amp_error, pos_ref_speed, speed_ff, force_ff;
    logic pos_ctrl_active, pos_complete, ref_complete, second_gain;
    logic signed [15:0] monitor_one_code, monitor_two_code, rec_one, rec_two;
    int fail_count, cmp_count;
    // Every documented selection; reserved codes stay out
    logic [7:0] ca [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08,
                            8'h09, 8'h0a, 8'h0b, 8'h0c};
    real va [11] = '{1.0, -2.0, 0.5, 1.0, -2.0, 3.0, 5.0, -1.0, -1.5, 2.0, 0.0};
    logic [7:0] cb [4] = '{8'h03, 8'h08, 8'h0b, 8'h0c};
    real vb [4] = '{0.0, 0.0, 1.0, 5.0};
    dam_top #(.SIG_W(24)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .motor_speed, .speed_ref, .force_ref, .pos_error, .amp_error, .pos_ref_speed,
        .speed_ff, .force_ff, .pos_ctrl_active, .pos_complete, .ref_complete,
        .second_gain, .monitor_one_code, .monitor_two_code);
    dam_recorder u_rec (.hclk, .hresetn, .ch_one(monitor_one_code),
        .ch_two(monitor_two_code), .rec_one, .rec_two);
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    task tally_and_finish();
        if (fail_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Bounded wait for hready sampled high at a rising edge
    task wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 20) begin
            @(posedge hclk);
            n++;
        end
    endtask
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'b10;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
    task cmp_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h00000000);
        cmp_word(rd, exp);
    endtask
    // Volts to code with clipping; small slack for the fixed-point gains
    task cmp_code(input logic signed [15:0] got, input real v);
        real c;
        int e;
        logic ok;
        c = -v * 4096.0;
        if (c > 32767.0) c = 32767.0;
        if (c < -32768.0) c = -32768.0;
        e = $rtoi(c);
        ok = (got >= e - 6) && (got <= e + 6);
        cmp_count++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e[15:0]);
        end
    endtask
    task settle();
        repeat (6) @(posedge hclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Watchdog, far beyond the roughly 200 cycles the run needs
    initial begin
        #(4000 * 50);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        {speed_ref, pos_error, amp_error, pos_ref_speed, speed_ff, force_ff} = '0;
        {pos_ctrl_active, pos_complete, ref_complete, second_gain} = '0;
        force_ref = 24'sh0003e8;
        motor_speed = -24'sh0001f4;
        fail_count = 0;
        cmp_count = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rd_chk(DAM_OFS_SEL1, 32'h00000002);
        rd_chk(DAM_OFS_SEL2, 32'h00000000);
        rd_chk(DAM_OFS_OFF1, 32'h00000000);
        rd_chk(DAM_OFS_OFF2, 32'h00000000);
        rd_chk(DAM_OFS_MAG1, 32'h00000064);
        xfer(8'h40, 1'b1, 32'h0000a5a5);
        rd_chk(8'h40, 32'h00000000);
        cmp_code(rec_one, 1.0);
        cmp_code(rec_two, -0.5);
        // Distinct level on most sources; motor_speed and pos_error both give 1 V, speed_ref and amp_error -2 V
        motor_speed <= 24'sh0003e8;
        speed_ref <= -24'sh0007d0;
        force_ref <= 24'sh0001f4;
        pos_error <= 24'sh000014;
        amp_error <= -24'sh000028;
        pos_ref_speed <= 24'sh000bb8;
        speed_ff <= -24'sh0003e8;
        force_ff <= -24'sh0005dc;
        {pos_ctrl_active, pos_complete, ref_complete, second_gain} <= 4'b1101;
        xfer(DAM_OFS_SEL2, 1'b1, 32'h00000004);
        settle();
        cmp_code(rec_two, -2.0);
        for (int i = 0; i < 11; i++) begin
            xfer(DAM_OFS_SEL1, 1'b1, {24'h000000, ca[i]});
            settle();
            cmp_code(rec_one, va[i]);
        end
        cmp_code(rec_two, -2.0);
        {pos_ctrl_active, pos_complete, ref_complete, second_gain} <= 4'b0010;
        for (int i = 0; i < 4; i++) begin
            xfer(DAM_OFS_SEL1, 1'b1, {24'h000000, cb[i]});
            settle();
            cmp_code(rec_one, vb[i]);
        end
        xfer(DAM_OFS_SEL1, 1'b1, 32'h00000002);
        xfer(DAM_OFS_MAG1, 1'b1, 32'h0000ffce);
        xfer(DAM_OFS_OFF1, 1'b1, 32'h0000000f);
        rd_chk(DAM_OFS_MAG1, 32'h0000ffce);
        settle();
        cmp_code(rec_one, 1.25);
        xfer(DAM_OFS_OFF1, 1'b1, 32'h00004e20);
        rd_chk(DAM_OFS_OFF1, 32'h00002710);
        settle();
        cmp_code(rec_one, 1000.0);
        xfer(DAM_OFS_OFF1, 1'b1, 32'h0000b1e0);
        rd_chk(DAM_OFS_OFF1, 32'h0000d8f0);
        settle();
        cmp_code(rec_one, -1000.0);
        rd_chk(DAM_OFS_STAT, 32'h00000001);
        xfer(DAM_OFS_SEL2, 1'b1, 32'h00000000);
        xfer(DAM_OFS_MAG2, 1'b1, 32'h000000c8);
        xfer(DAM_OFS_OFF2, 1'b1, 32'h0000fffb);
        settle();
        cmp_code(rec_two, 1.5);
        tally_and_finish();
    end
endmodule
